// File: design/tcp_pkg.sv
// constants for the tape control panel logic
package tcp_pkg;
   localparam int DEB_CYCLES = 16;
   localparam int DEB_CW = 5;
   // density codes: 00 means take from the unit selector
   localparam logic [1:0] DENS_FROM_SEL = 2'h0;
   localparam int DENS_HI_BIT = 13;
   localparam int DENS_LO_BIT = 12;
   localparam logic [3:0] FN_READ_FWD = 4'h1;
   localparam logic [3:0] FN_READ_BWD = 4'h2;
   localparam logic [3:0] FN_WRITE = 4'h3;
   localparam logic [3:0] FN_SKIP_WRITE = 4'h4;
   localparam int FN_CODE_HI = 17;
   localparam int FN_CODE_LO = 14;
   localparam int FN_WIDTH = 18;
   typedef enum logic [1:0] {
      CU_OFF = 2'h1,
      CU_ON = 2'h2
   } tcp_cu_e;
endpackage

// File: design/tcp_debounce.sv
// synchroniser, debouncer and press detector for one pushbutton
`timescale 1ns/1ps
`default_nettype none
module tcp_debounce #(
   parameter int CNT = tcp_pkg::DEB_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic rawIn,
   output logic level,
   output logic press
);
   logic sync1_r, sync2_r, stable_r, press_r;
   logic sync1_nxt, sync2_nxt, stable_nxt, press_nxt;
   logic [tcp_pkg::DEB_CW-1:0] cnt_r, cnt_nxt;

   always_comb begin
      sync1_nxt = rawIn;
      sync2_nxt = sync1_r;
      stable_nxt = stable_r;
      cnt_nxt = '0;
      press_nxt = 1'b0;
      if (sync2_r != stable_r) begin
         cnt_nxt = cnt_r + 1'b1;
         if (cnt_r == tcp_pkg::DEB_CW'(CNT - 1)) begin
            stable_nxt = sync2_r;
            press_nxt = sync2_r;
            cnt_nxt = '0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         stable_r <= 1'b0;
         press_r <= 1'b0;
         cnt_r <= '0;
      end else if (ce) begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
         stable_r <= stable_nxt;
         press_r <= press_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign level = stable_r;
   assign press = press_r;
endmodule
`default_nettype wire

// File: design/tcp_panel.sv
// control unit and tape unit panel logic with density selection
//
// Contract
// - unit ON clears OFF only if mounted
// - unit OFF press forgets past-warning state
// - unit presents three-way density selector
// - density-class word, density bits zero: sample selector at start
// - density-class word, density bits nonzero: use function word density
// - ON press while OFF lit: on, master clear
// - ON ignored if ON lit or OFF dark
// - OFF press while ON lit turns off
// - OFF ignored unless ON lit
// - power-up shows OFF lit, ON dark
// - CLEAR with ON lit master clears; code: an OFF press in the same cycle wins, turns off, no master clear
// - CLEAR lamp follows held switch while ON
// - CLEAR ignored whenever ON dark
`timescale 1ns/1ps
`default_nettype none
module tcp_panel #(
   parameter int DEB = tcp_pkg::DEB_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic cuOnBtn,
   input wire logic cuOffBtn,
   input wire logic cuClearBtn,
   input wire logic tuOnBtn,
   input wire logic tuOffBtn,
   input wire logic tapeMounted,
   input wire logic [1:0] densitySel,
   input wire logic pastWarnSet,
   input wire logic fnValid,
   input wire logic [tcp_pkg::FN_WIDTH-1:0] fnWord,
   output logic cuOnLamp,
   output logic cuOffLamp,
   output logic cuClearLamp,
   output logic masterClear,
   output logic fnReady,
   output logic tuOnLamp,
   output logic tuOffLamp,
   output logic pastWarn,
   output logic [1:0] unitDensity,
   output logic [1:0] opDensity,
   output logic opStart
);
   ////////////////////////////////////////////////////////////////
   logic [4:0] raw, lvl, prs;
   assign raw = {tuOffBtn, tuOnBtn, cuClearBtn, cuOffBtn, cuOnBtn};

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_btn
         tcp_debounce #(.CNT(DEB)) u_deb (
            .clk(clk),
            .rst_n(rst_n),
            .ce(ce),
            .rawIn(raw[gi]),
            .level(lvl[gi]),
            .press(prs[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////
   tcp_pkg::tcp_cu_e cu_r, cu_nxt;
   logic clrLamp_r, clrLamp_nxt, mclr_r, mclr_nxt, ready_r, ready_nxt;
   // lamps get their own flops so no output is decoded from state
   logic onLamp_r, onLamp_nxt, offLamp_r, offLamp_nxt;

   always_comb begin
      cu_nxt = cu_r;
      mclr_nxt = 1'b0;
      ready_nxt = ready_r;
      clrLamp_nxt = 1'b0;
      case (cu_r)
         tcp_pkg::CU_OFF: begin
            if (prs[0]) begin
               cu_nxt = tcp_pkg::CU_ON;
               mclr_nxt = 1'b1;
               ready_nxt = 1'b1;
            end
         end
         tcp_pkg::CU_ON: begin
            if (prs[1]) begin
               cu_nxt = tcp_pkg::CU_OFF;
               ready_nxt = 1'b0;
            end else begin
               clrLamp_nxt = lvl[2];
               if (prs[2]) begin
                  mclr_nxt = 1'b1;
                  ready_nxt = 1'b1;
               end else if (fnValid && ready_r) begin
                  ready_nxt = 1'b0;
               end
            end
         end
         default: begin
            cu_nxt = tcp_pkg::CU_OFF;
            ready_nxt = 1'b0;
         end
      endcase
      onLamp_nxt = (cu_nxt == tcp_pkg::CU_ON);
      offLamp_nxt = (cu_nxt == tcp_pkg::CU_OFF);
   end

   // reset lands in the OFF state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cu_r <= tcp_pkg::CU_OFF;
         onLamp_r <= 1'b0;
         offLamp_r <= 1'b1;
         clrLamp_r <= 1'b0;
         mclr_r <= 1'b0;
         ready_r <= 1'b0;
      end else if (ce) begin
         cu_r <= cu_nxt;
         onLamp_r <= onLamp_nxt;
         offLamp_r <= offLamp_nxt;
         clrLamp_r <= clrLamp_nxt;
         mclr_r <= mclr_nxt;
         ready_r <= ready_nxt;
      end
   end

   assign cuOnLamp = onLamp_r;
   assign cuOffLamp = offLamp_r;
   assign cuClearLamp = clrLamp_r;
   assign masterClear = mclr_r;
   assign fnReady = ready_r;

   ////////////////////////////////////////////////////////////////
   logic tuOn_r, tuOn_nxt, tuOff_r, tuOff_nxt, warn_r, warn_nxt;

   always_comb begin
      tuOn_nxt = tuOn_r;
      tuOff_nxt = tuOff_r;
      warn_nxt = warn_r | pastWarnSet;
      if (prs[4]) begin
         tuOn_nxt = 1'b0;
         tuOff_nxt = 1'b1;
         warn_nxt = 1'b0;
      end else if (prs[3] && tuOff_r && !tuOn_r) begin
         tuOn_nxt = 1'b1;
         tuOff_nxt = !tapeMounted;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tuOn_r <= 1'b0;
         tuOff_r <= 1'b1;
         warn_r <= 1'b0;
      end else if (ce) begin
         tuOn_r <= tuOn_nxt;
         tuOff_r <= tuOff_nxt;
         warn_r <= warn_nxt;
      end
   end

   assign tuOnLamp = tuOn_r;
   assign tuOffLamp = tuOff_r;
   assign pastWarn = warn_r;

   ////////////////////////////////////////////////////////////////
   logic [1:0] unitDen_r, unitDen_nxt, opDen_r, opDen_nxt;
   logic start_r, start_nxt;
   logic [3:0] fnCode;
   logic [1:0] fnDen;
   logic densFn;
   assign fnCode = fnWord[tcp_pkg::FN_CODE_HI:tcp_pkg::FN_CODE_LO];
   assign fnDen = fnWord[tcp_pkg::DENS_HI_BIT:tcp_pkg::DENS_LO_BIT];
   assign densFn = (fnCode == tcp_pkg::FN_READ_FWD) || (fnCode == tcp_pkg::FN_READ_BWD) ||
      (fnCode == tcp_pkg::FN_WRITE) || (fnCode == tcp_pkg::FN_SKIP_WRITE);

   always_comb begin
      // selector presented to the control unit
      unitDen_nxt = densitySel;
      opDen_nxt = opDen_r;
      start_nxt = 1'b0;
      if (fnValid && ready_r && cuOnLamp && !prs[1] && !prs[2]) begin
         start_nxt = 1'b1;
         if (densFn) begin
            opDen_nxt = (fnDen == tcp_pkg::DENS_FROM_SEL) ? unitDen_r : fnDen;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         unitDen_r <= 2'h0;
         opDen_r <= 2'h0;
         start_r <= 1'b0;
      end else if (ce) begin
         unitDen_r <= unitDen_nxt;
         opDen_r <= opDen_nxt;
         start_r <= start_nxt;
      end
   end

   assign unitDensity = unitDen_r;
   assign opDensity = opDen_r;
   assign opStart = start_r;
endmodule
`default_nettype wire

// File: dv/tcp_host_model.sv
// processor model offering function words
`timescale 1ns/1ps
`default_nettype none
module tcp_host_model (
   input wire logic clk,
   input wire logic req,
   input wire logic [17:0] reqWord,
   input wire logic opStart,
   output logic fnValid,
   output logic [17:0] fnWord
);
   initial begin
      fnValid = 1'b0;
      fnWord = 18'h0;
   end
   always @(negedge clk) begin
      if (opStart) begin
         fnValid <= 1'b0;
         // released bus, stale word inverted
         fnWord <= ~fnWord;
      end else if (req) begin
         fnValid <= 1'b1;
         fnWord <= reqWord;
      end
   end
endmodule
`default_nettype wire

// File: dv/tcp_panel_assertions.sv
// panel checker
`timescale 1ns/1ps
`default_nettype none
module tcp_panel_assertions (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tapeMounted,
   input wire logic [17:0] fnWord,
   input wire logic [1:0] unitDensity,
   input wire logic [1:0] opDensity,
   input wire logic opStart,
   input wire logic fnReady,
   input wire logic masterClear,
   input wire logic cuOnLamp,
   input wire logic cuOffLamp,
   input wire logic cuClearLamp,
   input wire logic tuOnLamp,
   input wire logic tuOffLamp,
   input wire logic pastWarn
);
   logic [17:0] w_r, w_nxt;
   logic [1:0] s_r, s_nxt;
   logic cls;
   always_comb begin
      w_nxt = fnWord;
      s_nxt = unitDensity;
   end
   always_ff @(posedge clk) begin
      w_r <= w_nxt;
      s_r <= s_nxt;
   end
   // only density-class words pick a density
   assign cls = w_r[17:14] inside {4'h1, 4'h2, 4'h3, 4'h4};
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence startEnd;
      !fnReady ##1 !opStart;
   endsequence
   a_lamps_exclusive: assert property (cuOnLamp != cuOffLamp) else $error("lamps");
   a_clear_needs_on: assert property (cuClearLamp |-> cuOnLamp) else $error("clear lamp");
   a_clear_prepares: assert property (masterClear |-> fnReady && cuOnLamp) else $error("clear");
   a_start_pulse: assert property (opStart |-> startEnd) else $error("start");
   a_dens_word: assert property (opStart && cls && w_r[13:12] != 2'h0 |-> opDensity == w_r[13:12])
      else $error("word density");
   a_dens_sel: assert property (opStart && cls && w_r[13:12] == 2'h0 |-> opDensity == s_r)
      else $error("sel density");
   a_unit_on: assert property ($rose(tuOnLamp) |-> tuOffLamp == !tapeMounted) else $error("unit on");
   a_unit_forget: assert property ($fell(tuOnLamp) |-> tuOffLamp && !pastWarn) else $error("forget");
endmodule
`default_nettype wire

// File: dv/test_tcp_panel.sv
// bench for the panel logic
`timescale 1ns/1ps
`default_nettype none
module test_tcp_panel;
   logic clk = 0, rst_n = 0, ce = 1, tapeMounted = 1, pastWarnSet = 0, req = 0;
   logic [4:0] b = 5'h0;
   logic [1:0] densitySel = 2'h0, unitDensity, opDensity, mc, cl, st;
   logic [17:0] reqWord = 18'h0, fnWord;
   logic fnValid, cuOnLamp, cuOffLamp, cuClearLamp, masterClear, fnReady, tuOnLamp, tuOffLamp, pastWarn, opStart;
   // code, density bits, selector, expected
   // last row: non-density code keeps the held density
   logic [9:0] rows [7] = '{10'h045, 10'h08A, 10'h0CF, 10'h119, 10'h066, 10'h0F3, 10'h153};
   int n_mismatch = 0, tests_run = 0;
   always #20 clk = ~clk;
   // short debounce keeps the run brief
   tcp_panel #(.DEB(2)) dut_u (.cuOnBtn(b[0]), .cuOffBtn(b[1]), .cuClearBtn(b[2]), .tuOnBtn(b[3]), .tuOffBtn(b[4]), .*);
   tcp_host_model host_u (.*);
   task chk(input logic [1:0] g, input logic [1:0] e);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t got %b want %b", $time, g, e);
      end
   endtask
   task press(input int i);
      mc = 0;
      cl = 0;
      b[i] <= 1'b1;
      repeat (10) begin
         @(negedge clk);
         mc += masterClear;
         cl |= cuClearLamp;
      end
      b[i] <= 1'b0;
      repeat (10) @(negedge clk);
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (3) @(negedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      press(0);
      foreach (rows[i]) begin
         densitySel <= rows[i][3:2];
         press(2);
         reqWord <= {rows[i][9:4], 12'h0};
         req <= 1'b1;
         @(negedge clk);
         req <= 1'b0;
         st = 0;
         repeat (4) begin
            @(negedge clk);
            st += opStart;
         end
         chk(st, 2'h1);
         chk(opDensity, rows[i][1:0]);
         chk({1'b0, fnReady}, 2'h0);
      end
      chk(unitDensity, 2'h0);
      $display("rows done");
      rst_n <= 1'b0;
      @(negedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk({cuOnLamp, cuOffLamp}, 2'h1);
      press(2);
      chk({cl[0], mc[0]}, 2'h0);
      press(1);
      chk({cuOnLamp, cuOffLamp}, 2'h1);
      press(0);
      chk({mc[0], fnReady}, 2'h3);
      press(0);
      chk({mc[0], cuOnLamp}, 2'h1);
      press(2);
      chk({cl[0], mc[0]}, 2'h3);
      chk({cuClearLamp, fnReady}, 2'h1);
      press(1);
      chk({cuOnLamp, cuOffLamp}, 2'h1);
      ce <= 1'b0;
      press(0);
      ce <= 1'b1;
      repeat (10) @(negedge clk);
      chk({cuOnLamp, cuOffLamp}, 2'h1);
      $display("panel done");
      press(3);
      pastWarnSet <= 1'b1;
      @(negedge clk);
      pastWarnSet <= 1'b0;
      @(negedge clk);
      chk({tuOffLamp, pastWarn}, 2'h1);
      press(4);
      chk({tuOnLamp, pastWarn}, 2'h0);
      tapeMounted <= 1'b0;
      press(3);
      chk({tuOnLamp, tuOffLamp}, 2'h3);
      $display("tape unit done");
      complete_run;
   end
   initial begin
      repeat (3000) @(posedge clk);
      n_mismatch++;
      complete_run;
   end
endmodule
bind tcp_panel tcp_panel_assertions chk_u (.*);
`default_nettype wire
